// ===== bench/bwp_pad_model.sv
/*
  package pins around the port: resolves each pin level.
  assumes the bench sets extEn only on input pins; extVal counts only where extEn is set.
*/
`timescale 1ns/10ps
module bwp_pad_model (
  input wire logic clk,
  input wire logic [7:0] padOut,
  input wire logic [7:0] padOe,
  input wire logic [7:0] padPullup,
  input wire logic [7:0] extVal,
  input wire logic [7:0] extEn,
  output logic [7:0] padIn
);
  logic [7:0] held = 8'h00; // last level, for floating pins
  // keep last level so a floating pin can flip
  always @(posedge clk)
    held <= padIn;
  // floating and unpulled: no stale value survives
  assign padIn = (padOe & padOut) | (~padOe & extEn & extVal)
    | (~padOe & ~extEn & (padPullup | ~held));
endmodule // bwp_pad_model

// ===== bench/bwp_port_props.sv
/*
  concurrent checks on the port block's bus and pad pins.
  assumes binding to bwp_port, one clock, async active-low reset.
*/
`timescale 1ns/10ps
module bwp_port_props #(
  parameter int PINS = 8
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic rvalid,
  input wire logic rready,
  input wire logic [PINS-1:0] padOe,
  input wire logic [PINS-1:0] padPullup,
  input wire logic [PINS-1:0] lcdSegmentSel
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // both halves of an idle write taken together
  sequence wrBoth;
    awvalid && awready && wvalid && wready && !bvalid;
  endsequence
  // slot closes, then the answer one edge later
  sequence wrAnswer;
    !awready ##1 bvalid;
  endsequence
  a_write_answer: assert property (wrBoth |=> wrAnswer)
    else $error("write answer not on time");
  a_bresp_gap: assert property (bvalid && bready |=> !bvalid)
    else $error("write answer repeated");
  a_read_answer: assert property (arvalid && arready |=> rvalid && !arready)
    else $error("read answer not on time");
  a_read_gap: assert property (rvalid && rready |=> !rvalid && arready)
    else $error("read answer repeated");
  a_rdata_top: assert property (rvalid |-> (rdata >> 8) == 32'h0000_0000)
    else $error("upper read bits set");
  a_seg_drive: assert property ((padOe & lcdSegmentSel) == lcdSegmentSel)
    else $error("segment pin not driven");
  a_seg_pull: assert property ((padPullup & lcdSegmentSel) == '0)
    else $error("pull-up on segment pin");
  a_out_pull: assert property ((padPullup & padOe) == '0)
    else $error("pull-up on driven pin");
  a_reset_pins: assert property ($rose(rst_n) |-> padOe == '0 && padPullup == '0)
    else $error("pins not idle after reset");
endmodule // bwp_port_props
bind bwp_port bwp_port_props #(.PINS(PINS)) bwp_port_props_inst (.clk, .rst_n, .awvalid,
  .awready, .wvalid, .wready, .bvalid, .bready, .arvalid, .arready, .rdata, .rvalid,
  .rready, .padOe, .padPullup, .lcdSegmentSel);

// ===== bench/bwp_port_test.sv
/*
  self-checking bench for the port block over axi4-lite.
  assumes bwp_port, the pad model and the checker are compiled first.
*/
`timescale 1ns/10ps
`define CHK(g, e) begin samplesChecked++; if ((g) !== (e)) begin errTotal++; \
  $display("mismatch at %0t got %h exp %h", $time, g, e); end end
module bwp_port_test;
  logic clk, rst_n, awvalid, wvalid, bready, arvalid, rready, pulseGenOutput, padChk;
  logic awready, wready, bvalid, arready, rvalid;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic [7:0] padIn, padOut, padOe, padPullup, lcdSegmentDrive, lcdSegmentSel, extVal, extEn;
  logic [7:0] latV, dirV, puV, segV, plsV, v; // shadow of the registers
  logic [33:0] q[$]; // expected results, oldest first
  logic [33:0] ex;
  int errTotal, samplesChecked, seed, i;
  bwp_port bwp_port_inst (.clk(clk), .rst_n(rst_n), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .padIn(padIn), .padOut(padOut), .padOe(padOe), .padPullup(padPullup),
    .lcdSegmentDrive(lcdSegmentDrive), .lcdSegmentSel(lcdSegmentSel),
    .pulseGenOutput(pulseGenOutput));
  bwp_pad_model bwp_pad_model_inst (.clk(clk), .padOut(padOut), .padOe(padOe),
    .padPullup(padPullup), .extVal(extVal), .extEn(extEn), .padIn(padIn));
  // 100 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // watcher: each answer takes the oldest note
  always @(posedge clk)
  begin
    if (rvalid || bvalid || padChk)
    begin
      ex = q.pop_front();
      if (rvalid) `CHK({rresp, rdata}, ex)
      else if (bvalid) `CHK({bresp, 32'h0000_0000}, ex)
      else `CHK({2'b00, lcdSegmentSel, padOe, padOut & padOe, padPullup}, ex)
    end
  end
  task giveVerdict;
    begin
      $display("checked %0d mismatches %0d", samplesChecked, errTotal);
      if (errTotal == 0 && samplesChecked > 0)
        $display("Regression OK");
      else
        $display("Regression broken");
      $finish;
    end
  endtask
  // a hung wait counts and ends the run
  task tmo;
    begin
      errTotal++;
      giveVerdict();
    end
  endtask
  // reset: 16 cycles low, shadow back to reset values
  task rst;
    begin
      rst_n <= 1'b0;
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      {latV, dirV, puV, segV, plsV} = {8'h00, 8'hFF, 24'h0000_00};
    end
  endtask
  // one write; bready stays high, so the answer is taken when seen
  task wr(input logic [11:0] a, input logic [7:0] d, input logic s, input logic [1:0] r);
    int n;
    begin
      q.push_back({r, 32'h0000_0000});
      {awaddr, wdata, wstrb} <= {a, 24'h0000_00, d, 3'b000, s};
      {awvalid, wvalid} <= 2'b11;
      n = 0;
      do
      begin
        @(posedge clk);
        if (awvalid && awready) awvalid <= 1'b0;
        if (wvalid && wready) wvalid <= 1'b0;
        n++;
      end while (n < 50 && !bvalid);
      if (n == 50 && !bvalid) tmo();
      if (s && r == 2'b00)
        case (a)
          12'h000, 12'h004: latV = d;
          12'h008: dirV = d;
          12'h00C: puV = d;
          12'h010: segV = d;
          12'h014: plsV = d;
          default: ;
        endcase
    end
  endtask
  task rd(input logic [11:0] a, input logic [7:0] e, input logic [1:0] r);
    int n;
    begin
      q.push_back({r, 24'h0000_00, e});
      araddr <= a;
      arvalid <= 1'b1;
      n = 0;
      do
      begin
        @(posedge clk);
        if (arvalid && arready) arvalid <= 1'b0;
        n++;
      end while (n < 50 && !rvalid);
      if (n == 50 && !rvalid) tmo();
    end
  endtask
  // pad expectation: segment over pulse over direction
  task pads;
    logic [7:0] oe, out, pl, pm;
    begin
      pm = plsV[0] ? 8'h01 & ~segV : 8'h00;
      oe = segV | pm | ~dirV;
      out = (segV & lcdSegmentDrive) | (pm & {8{pulseGenOutput}}) | (~segV & ~pm & ~dirV & latV);
      pl = {8{puV[7]}} & dirV & ~segV & ~pm;
      // segment select mirrors the enable word one edge later
      q.push_back({2'b00, segV, oe, out, pl});
      padChk <= 1'b1;
      @(posedge clk);
      padChk <= 1'b0;
      @(posedge clk);
    end
  endtask
  initial
  begin
    {awvalid, wvalid, arvalid, padChk, pulseGenOutput} = 5'h00;
    {bready, rready} = 2'b11; // always ready for answers
    {awaddr, araddr, wdata, wstrb} = 60'h0000_0000_0000_000;
    {lcdSegmentDrive, extVal, extEn} = 24'h0000_00;
    {errTotal, samplesChecked, seed} = {32'd0, 32'd0, 32'd14};
    rst();
    for (i = 1; i < 6; i++)
      rd(12'(4 * i), i == 2 ? 8'hFF : 8'h00, 2'b00);
    rd(12'h018, 8'h00, 2'b10);
    pads();
    $display("reset values done");
    wr(12'h00C, 8'h80, 1'b1, 2'b00);
    pads();
    rd(12'h000, 8'hFF, 2'b00);
    wr(12'h00C, 8'h00, 1'b1, 2'b00);
    pads();
    $display("pull-up test done");
    for (i = 0; i < 6; i++)
    begin
      v = 8'($random(seed));
      extVal <= 8'($random(seed));
      wr(12'h008, v, 1'b1, 2'b00);
      extEn <= v;
      wr(i[0] ? 12'h000 : 12'h004, 8'($random(seed)), 1'b1, 2'b00);
      wr(12'h00C, 8'($random(seed)), 1'b1, 2'b00);
      pads();
      rd(12'h000, (~dirV & latV) | (dirV & extVal), 2'b00);
      rd(12'h004, latV, 2'b00);
    end
    wr(12'h004, ~latV, 1'b0, 2'b00);
    rd(12'h004, latV, 2'b00);
    wr(12'h018, 8'hFF, 1'b1, 2'b10);
    $display("direction test done");
    lcdSegmentDrive <= 8'($random(seed));
    // opposite of the latch bit, so a latch-driven pin 0 cannot pass for the pulse
    pulseGenOutput <= ~latV[0];
    wr(12'h014, 8'h01, 1'b1, 2'b00);
    wr(12'h010, 8'($random(seed)) | 8'h01, 1'b1, 2'b00);
    pads();
    wr(12'h010, 8'h00, 1'b1, 2'b00);
    pads();
    $display("segment test done");
    rst();
    rd(12'h008, 8'hFF, 2'b00);
    pads();
    $display("second reset done");
    giveVerdict();
  end
endmodule // bwp_port_test

// ===== hw/bwp_pin_sync.sv
/*
  two-flop synchroniser for the pad input levels.
  assumes pads are asynchronous to clk; only the second stage reads the first.
*/
`timescale 1ns/10ps
module bwp_pin_sync #(
  parameter int WIDTH = 8
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] asyncIn,
  output logic [WIDTH-1:0] syncOut
);
  // first stage, read only by the second
  logic [WIDTH-1:0] metaStage;

  // two stages against metastability; levels only, no edge detection
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      metaStage <= '0;
      syncOut <= '0;
    end
    else
    begin
      metaStage <= asyncIn;
      syncOut <= metaStage;
    end
  end
endmodule // bwp_pin_sync

// ===== hw/bwp_pkg.sv
/*
  types shared by the port block.
  assumes the register header is compiled alongside.
*/
package bwp_pkg;
  // register select decoded from a word address
  typedef enum logic [2:0] {
    BWP_SEL_PIN = 3'b000,
    BWP_SEL_LAT = 3'b001,
    BWP_SEL_DIR = 3'b010,
    BWP_SEL_PU = 3'b011,
    BWP_SEL_SEG = 3'b100,
    BWP_SEL_PLS = 3'b101,
    BWP_SEL_BAD = 3'b111
  } bwp_sel_e;
endpackage

// ===== hw/bwp_port.sv
/*
  eight-pin general-purpose port with weak pull-ups, lcd segment sharing
  and a pulse generator output on pin 0, reached over axi4-lite.
  assumes pads are resolved outside from out/oe/pull-up enables, and that
  the segment drive and pulse generator levels come from logic on clk.
*/
`timescale 1ns/10ps
`include "bwp_regs.svh"
module bwp_port #(
  parameter int PINS = 8
) (
  input wire logic clk,
  input wire logic rst_n,
  // axi4-lite write address
  input wire logic [11:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  // axi4-lite write data
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  // axi4-lite write response
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // axi4-lite read address
  input wire logic [11:0] araddr,
  input wire logic arvalid,
  output logic arready,
  // axi4-lite read data
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // pads
  input wire logic [PINS-1:0] padIn,
  output logic [PINS-1:0] padOut,
  output logic [PINS-1:0] padOe,
  output logic [PINS-1:0] padPullup,
  // lcd segment drive levels and their select
  input wire logic [PINS-1:0] lcdSegmentDrive,
  output logic [PINS-1:0] lcdSegmentSel,
  // charge-time unit pulse generator output level
  input wire logic pulseGenOutput
);
  // the register map and byte lanes are fixed at eight pins; refused at elaboration
  if (PINS != 8)
  begin : g_pins_check
    $error("bwp_port supports exactly 8 pins");
  end

  // software-visible state
  logic [PINS-1:0] outputLatchValue;
  logic [PINS-1:0] pinDirectionCtrl;
  logic [7:0] pullupAndAuxPins; // bit 7 global pull-up enable
  logic [PINS-1:0] segmentEnableLow;
  logic [7:0] pulseCtrl; // bit 0 routes pulse generator to pin 0
  logic [PINS-1:0] pinLevel; // synchronised pad levels

  // write channel capture; address and data may arrive in either order
  logic awHeld;
  logic wHeld;
  logic [11:0] awAddrHeld;
  logic [31:0] wDataHeld;
  logic [3:0] wStrbHeld;
  logic doWrite;
  bwp_pkg::bwp_sel_e wrSel;
  bwp_pkg::bwp_sel_e rdSel;
  logic globalPullupEnable;
  logic pulseOnPin0;
  logic [PINS-1:0] next_padOut;
  logic [PINS-1:0] next_padOe;
  logic [PINS-1:0] next_padPullup;
  logic [31:0] next_rdata;

  // word decode shared by both channels
  function automatic bwp_pkg::bwp_sel_e decodeAddr(input logic [11:0] addr);
    bwp_pkg::bwp_sel_e sel;
    sel = bwp_pkg::BWP_SEL_BAD;
    case (addr)
      `BWP_OFF_PIN_LEVEL: sel = bwp_pkg::BWP_SEL_PIN;
      `BWP_OFF_LATCH: sel = bwp_pkg::BWP_SEL_LAT;
      `BWP_OFF_DIR: sel = bwp_pkg::BWP_SEL_DIR;
      `BWP_OFF_PULLUP: sel = bwp_pkg::BWP_SEL_PU;
      `BWP_OFF_SEGEN: sel = bwp_pkg::BWP_SEL_SEG;
      `BWP_OFF_PULSE: sel = bwp_pkg::BWP_SEL_PLS;
      default: sel = bwp_pkg::BWP_SEL_BAD;
    endcase
    return sel;
  endfunction

  // pad levels cross into clk before anything reads them
  bwp_pin_sync #(
    .WIDTH(PINS)
  ) u_pin_sync (
    .clk(clk),
    .rst_n(rst_n),
    .asyncIn(padIn),
    .syncOut(pinLevel)
  );

  // write fires once both halves are held and no response is pending
  assign doWrite = awHeld && wHeld && !bvalid;
  assign wrSel = decodeAddr(awAddrHeld);
  assign rdSel = decodeAddr(araddr);
  assign globalPullupEnable = pullupAndAuxPins[`BWP_PULLUP_EN_BIT];
  assign pulseOnPin0 = pulseCtrl[`BWP_PULSE_EN_BIT];

  // write address acceptance; ready only while the slot is empty
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      awHeld <= 1'b0;
      awAddrHeld <= 12'h000;
      awready <= 1'b1;
    end
    else if (awvalid && awready)
    begin
      awHeld <= 1'b1;
      awAddrHeld <= {awaddr[11:2], 2'b00};
      awready <= 1'b0;
    end
    else if (doWrite)
    begin
      awHeld <= 1'b0;
      awready <= 1'b1;
    end
  end

  // write data acceptance, mirrors the address slot
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wHeld <= 1'b0;
      wDataHeld <= 32'h0000_0000;
      wStrbHeld <= 4'h0;
      wready <= 1'b1;
    end
    else if (wvalid && wready)
    begin
      wHeld <= 1'b1;
      wDataHeld <= wdata;
      wStrbHeld <= wstrb;
      wready <= 1'b0;
    end
    else if (doWrite)
    begin
      wHeld <= 1'b0;
      wready <= 1'b1;
    end
  end

  // write response; unmapped words answer slverr and change nothing
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      bvalid <= 1'b0;
      bresp <= `BWP_RESP_OKAY;
    end
    else if (doWrite)
    begin
      bvalid <= 1'b1;
      bresp <= (wrSel == bwp_pkg::BWP_SEL_BAD) ? `BWP_RESP_SLVERR : `BWP_RESP_OKAY;
    end
    else if (bready)
    begin
      bvalid <= 1'b0;
    end
  end

  // output latch; both the pin-level and latch words land here
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      outputLatchValue <= `BWP_RST_LATCH;
    else if (doWrite && wStrbHeld[0] &&
             (wrSel == bwp_pkg::BWP_SEL_PIN || wrSel == bwp_pkg::BWP_SEL_LAT))
      outputLatchValue <= wDataHeld[PINS-1:0];
  end

  // direction register, all inputs after reset
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      pinDirectionCtrl <= `BWP_RST_DIR;
    else if (doWrite && wStrbHeld[0] && wrSel == bwp_pkg::BWP_SEL_DIR)
      pinDirectionCtrl <= wDataHeld[PINS-1:0];
  end

  // shared pull-up word; enable clear at reset keeps pull-ups off
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      pullupAndAuxPins <= `BWP_RST_PULLUP;
    else if (doWrite && wStrbHeld[0] && wrSel == bwp_pkg::BWP_SEL_PU)
      pullupAndAuxPins <= wDataHeld[7:0];
  end

  // segment enables, one per pin
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      segmentEnableLow <= `BWP_RST_SEGEN;
    else if (doWrite && wStrbHeld[0] && wrSel == bwp_pkg::BWP_SEL_SEG)
      segmentEnableLow <= wDataHeld[PINS-1:0];
  end

  // pulse routing control for pin 0
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      pulseCtrl <= `BWP_RST_PULSE;
    else if (doWrite && wStrbHeld[0] && wrSel == bwp_pkg::BWP_SEL_PLS)
      pulseCtrl <= wDataHeld[7:0];
  end

  // pin function mux: segment beats pulse beats port direction
  always_comb
  begin
    for (int i = 0; i < PINS; i++)
    begin
      if (segmentEnableLow[i])
      begin
        // segment owns the pad; port drive and pull-up off
        next_padOut[i] = lcdSegmentDrive[i];
        next_padOe[i] = 1'b1;
        next_padPullup[i] = 1'b0;
      end
      else if (i == 0 && pulseOnPin0)
      begin
        // pulse generator drives regardless of direction
        next_padOut[i] = pulseGenOutput;
        next_padOe[i] = 1'b1;
        next_padPullup[i] = 1'b0;
      end
      else
      begin
        // ordinary port: 0 drives latch, 1 listens
        next_padOut[i] = outputLatchValue[i];
        next_padOe[i] = !pinDirectionCtrl[i];
        next_padPullup[i] = globalPullupEnable && pinDirectionCtrl[i];
      end
    end
  end

  // registered pad controls; one cycle behind the registers
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      padOut <= '0;
      padOe <= '0;
      padPullup <= '0;
      lcdSegmentSel <= '0;
    end
    else
    begin
      padOut <= next_padOut;
      padOe <= next_padOe;
      padPullup <= next_padPullup;
      lcdSegmentSel <= segmentEnableLow;
    end
  end

  // read data mux; unused upper bits read zero
  always_comb
  begin
    next_rdata = 32'h0000_0000;
    case (rdSel)
      bwp_pkg::BWP_SEL_PIN: next_rdata[PINS-1:0] = pinLevel;
      bwp_pkg::BWP_SEL_LAT: next_rdata[PINS-1:0] = outputLatchValue;
      bwp_pkg::BWP_SEL_DIR: next_rdata[PINS-1:0] = pinDirectionCtrl;
      bwp_pkg::BWP_SEL_PU: next_rdata[7:0] = pullupAndAuxPins;
      bwp_pkg::BWP_SEL_SEG: next_rdata[PINS-1:0] = segmentEnableLow;
      bwp_pkg::BWP_SEL_PLS: next_rdata[7:0] = pulseCtrl;
      default: next_rdata = 32'h0000_0000;
    endcase
  end

  // read channel: one read in flight, answered the cycle after address
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      arready <= 1'b1;
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= `BWP_RESP_OKAY;
    end
    else if (arvalid && arready)
    begin
      arready <= 1'b0;
      rvalid <= 1'b1;
      rdata <= next_rdata;
      rresp <= (rdSel == bwp_pkg::BWP_SEL_BAD) ? `BWP_RESP_SLVERR : `BWP_RESP_OKAY;
    end
    else if (rvalid && rready)
    begin
      rvalid <= 1'b0;
      arready <= 1'b1;
    end
  end
endmodule // bwp_port

// ===== hw/bwp_regs.svh
/*
  register offsets, field positions, reset values for the byte-wide
  general-purpose port with lcd segment sharing.
  assumes a 32-bit axi4-lite slave with one register per aligned word.
*/
`ifndef BWP_REGS_SVH
`define BWP_REGS_SVH
`define BWP_OFF_PIN_LEVEL 12'h000
`define BWP_OFF_LATCH 12'h004
`define BWP_OFF_DIR 12'h008
`define BWP_OFF_PULLUP 12'h00C
`define BWP_OFF_SEGEN 12'h010
`define BWP_OFF_PULSE 12'h014
`define BWP_PULLUP_EN_BIT 7
`define BWP_PULSE_EN_BIT 0
`define BWP_RST_LATCH 8'h00
`define BWP_RST_DIR 8'hFF
`define BWP_RST_PULLUP 8'h00
`define BWP_RST_SEGEN 8'h00
`define BWP_RST_PULSE 8'h00
`define BWP_RESP_OKAY 2'b00
`define BWP_RESP_SLVERR 2'b10
`endif
